// File: rss_delay_timer.sv
// Inter-strobe delay timer for the rail strobe sequencer
`timescale 1ns/10ps
module rss_delay_timer
    import rss_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
)
(
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        START_IN,
    input  wire logic [1:0]  CODE_IN,
    output logic             DONE_OUT
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             run_q;
    logic [CNT_W-1:0] load_val;

    // Delay code to cycles
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] code);
        int ms;
        case (code)
            2'b00:   ms = DLY0_MS;
            2'b01:   ms = DLY1_MS;
            2'b10:   ms = DLY2_MS;
            default: ms = DLY3_MS;
        endcase
        delay_cycles = CNT_W'(ms * MS_CYCLES);
    endfunction

    assign load_val = delay_cycles(CODE_IN);
    assign cnt_d    = START_IN ? load_val - CNT_W'(1) : cnt_q - CNT_W'(1);

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            cnt_q    <= '0;
            run_q    <= 1'b0;
            DONE_OUT <= 1'b0;
        end
        else
        begin
            DONE_OUT <= run_q && !START_IN && (cnt_q == CNT_W'(1));
            if (START_IN || run_q)
                cnt_q <= cnt_d;
            if (START_IN)
                run_q <= 1'b1;
            else if (cnt_q == CNT_W'(1))
                run_q <= 1'b0;
        end
    end
endmodule

// File: rss_pkg.sv
// Package for the rail strobe sequencer configuration block
package rss_pkg;
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;
    localparam logic [7:0]  UVT_OFFSET        = 8'h18;
    localparam logic [7:0]  SLOT_FIRST_OFFSET = 8'h19;
    localparam logic [7:0]  SLOT_SECOND_OFFSET = 8'h1a;
    localparam logic [7:0]  UVT_RESET         = 8'h03;
    localparam logic [7:0]  UVT_WR_MASK       = 8'h07;
    localparam logic [7:0]  SLOT_FIRST_MASK   = 8'h77;
    localparam logic [7:0]  SLOT_SECOND_MASK  = 8'h7f;
    localparam logic [7:0]  SLOT_FIRST_RESET  = 8'h15;
    localparam logic [7:0]  SLOT_SECOND_RESET = 8'h5f;
    localparam logic [7:0]  DELAY_RESET       = 8'h00;
    localparam int          SLOT_HI_POS       = 4;
    localparam logic [3:0]  LAST_STROBE       = 4'hf;
    localparam logic [3:0]  LINREG_FIRST_RSVD = 4'ha;
    localparam logic [3:0]  LINREG_LAST_RSVD  = 4'hd;
    localparam logic [3:0]  LINREG_HIGH_MIN   = 4'he;
    localparam int          CLK_MHZ           = 100;
    localparam int          DLY0_MS           = 1;
    localparam int          DLY1_MS           = 2;
    localparam int          DLY2_MS           = 5;
    localparam int          DLY3_MS           = 10;
    localparam int          CYC_PER_MS        = CLK_MHZ * 1000;
    localparam int          CNT_W             = 24;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_STEP, SEQ_DONE} rss_state_t;
endpackage

// File: rss_top.sv
// Rail strobe sequencer: threshold and slot registers, strobe stepping, rail enables
// Function
// - Threshold and slot writes need protection unlocked
// - Threshold code bits 1..0, reset 11b
// - Threshold bits 7..3 read zero, ignore writes
// - Threshold bit 2 reserved read/write, reset 0
// - First slot register: buck one, buck two
// - Second slot register: buck three, linear regulator
// - Three-bit slot zero means unsequenced, else strobe
// - Linreg codes 0, 8, 9 unsequenced
// - Linreg 14, 15 strobes; 15 with system supply
// - Buck enables need power enable input high
// - Strobe delay codes 1, 2, 5, 10 ms
`timescale 1ns/10ps
module rss_top
    import rss_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
)
(
    input  wire logic                    CLK_IN,
    input  wire logic                    SYS_RST_IN,
    input  wire logic                    REG_WR_IN,
    input  wire logic [rss_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input  wire logic [rss_pkg::DATA_W-1:0] REG_WDATA_IN,
    input  wire logic                    WR_UNLOCKED_IN,
    input  wire logic                    POWER_ENABLE_INPUT_IN,
    input  wire logic [rss_pkg::DATA_W-1:0] SLOT_DELAY_CTRL_IN,
    output logic [rss_pkg::DATA_W-1:0]   REG_RDATA_OUT,
    output logic [1:0]                   UNDERVOLTAGE_THRESHOLD_CODE_OUT,
    output logic [3:0]                   STROBE_OUT,
    output logic                         BUCK_ONE_EN_OUT,
    output logic                         BUCK_TWO_EN_OUT,
    output logic                         BUCK_THREE_EN_OUT,
    output logic                         LINREG_ONE_EN_OUT,
    output logic                         SYSTEM_SUPPLY_EN_OUT,
    output logic                         SEQ_DONE_OUT
);
    logic [7:0]  uvt_q;
    logic [7:0]  slot1_q;
    logic [7:0]  slot2_q;
    logic [3:0]  strobe_q;
    logic [3:0]  strobe_d;
    logic [3:0]  en_q;
    logic        sys_q;
    rss_state_t  state_q;
    rss_state_t  state_d;
    logic        wr_ok;
    logic        wr_uvt;
    logic        wr_s1;
    logic        wr_s2;
    logic [7:0]  rdata_d;
    logic [2:0]  buck_one_slot;
    logic [2:0]  buck_two_slot;
    logic [2:0]  buck_three_slot;
    logic [3:0]  linreg_one_slot;
    logic [3:0]  hit;
    logic        sys_hit;
    logic        tmr_start;
    logic        tmr_done;
    logic [1:0]  dly_code;
    logic [3:0]  en_d;
    logic        tmr_kick;

    // Strobe at which a rail enables; zero when left unsequenced
    // Reserved codes 10 to 13 have bit 3 set and return zero, unsequenced like 8 and 9
    function automatic logic [3:0] linreg_strobe(input logic [3:0] code);
        if (code >= LINREG_HIGH_MIN)
            linreg_strobe = code;
        else if (code[3])
            linreg_strobe = 4'h0;
        else
            linreg_strobe = code;
    endfunction

    function automatic logic slot_hit(input logic [3:0] slot, input logic [3:0] strobe);
        slot_hit = (slot != 4'h0) && (slot == strobe);
    endfunction

    // Write decode, gated by protection unlock
    assign wr_ok  = REG_WR_IN && WR_UNLOCKED_IN;
    assign wr_uvt = wr_ok && (REG_ADDR_IN == UVT_OFFSET);
    assign wr_s1  = wr_ok && (REG_ADDR_IN == SLOT_FIRST_OFFSET);
    assign wr_s2  = wr_ok && (REG_ADDR_IN == SLOT_SECOND_OFFSET);

    assign rdata_d = (REG_ADDR_IN == UVT_OFFSET)         ? uvt_q   :
                     (REG_ADDR_IN == SLOT_FIRST_OFFSET)  ? slot1_q :
                     (REG_ADDR_IN == SLOT_SECOND_OFFSET) ? slot2_q : 8'h00;

    assign buck_one_slot   = slot1_q[SLOT_HI_POS+2:SLOT_HI_POS];
    assign buck_two_slot   = slot1_q[2:0];
    assign buck_three_slot = slot2_q[SLOT_HI_POS+2:SLOT_HI_POS];
    assign linreg_one_slot = slot2_q[3:0];

    assign hit[0]  = slot_hit({1'b0, buck_one_slot}, strobe_q);
    assign hit[1]  = slot_hit({1'b0, buck_two_slot}, strobe_q);
    assign hit[2]  = slot_hit({1'b0, buck_three_slot}, strobe_q);
    assign hit[3]  = slot_hit(linreg_strobe(linreg_one_slot), strobe_q);
    assign sys_hit = hit[3] && (linreg_one_slot == LAST_STROBE);

    // Delay field chosen by strobe position, four fields of two bits
    assign dly_code  = SLOT_DELAY_CTRL_IN[7 - 2*strobe_q[1:0] -: 2];
    assign tmr_start = (state_q == SEQ_STEP) && (strobe_q != LAST_STROBE);
    assign strobe_d  = strobe_q + 4'h1;
    assign en_d      = (state_q == SEQ_STEP) ? (en_q | hit) : en_q;

    // Timer loads on power-up from idle and after every strobe but the last
    assign tmr_kick  = tmr_start || (state_q == SEQ_IDLE && POWER_ENABLE_INPUT_IN);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SEQ_IDLE: if (POWER_ENABLE_INPUT_IN) state_d = SEQ_WAIT;
            SEQ_WAIT: if (tmr_done) state_d = SEQ_STEP;
            SEQ_STEP: state_d = (strobe_q == LAST_STROBE) ? SEQ_DONE : SEQ_WAIT;
            SEQ_DONE: state_d = SEQ_DONE;
            default:  state_d = SEQ_IDLE;
        endcase
        if (!POWER_ENABLE_INPUT_IN)
            state_d = SEQ_IDLE;
    end

    rss_delay_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .CLK_IN     (CLK_IN),
        .SYS_RST_IN (SYS_RST_IN),
        .START_IN   (tmr_kick),
        .CODE_IN    (dly_code),
        .DONE_OUT   (tmr_done)
    );

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            uvt_q   <= UVT_RESET;
            slot1_q <= SLOT_FIRST_RESET;
            slot2_q <= SLOT_SECOND_RESET;
        end
        else
        begin
            if (wr_uvt)
                uvt_q <= REG_WDATA_IN & UVT_WR_MASK;
            if (wr_s1)
                slot1_q <= REG_WDATA_IN & SLOT_FIRST_MASK;
            if (wr_s2)
                slot2_q <= REG_WDATA_IN & SLOT_SECOND_MASK;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            state_q       <= SEQ_IDLE;
            strobe_q      <= 4'h0;
            en_q          <= 4'h0;
            sys_q         <= 1'b0;
            REG_RDATA_OUT <= 8'h00;
        end
        else
        begin
            state_q       <= state_d;
            REG_RDATA_OUT <= rdata_d;
            if (!POWER_ENABLE_INPUT_IN)
            begin
                strobe_q <= 4'h0;
                en_q     <= 4'h0;
                sys_q    <= 1'b0;
            end
            else
            begin
                en_q <= en_d;
                if (state_q == SEQ_STEP && sys_hit)
                    sys_q <= 1'b1;
                if (state_q == SEQ_WAIT && tmr_done)
                    strobe_q <= strobe_d;
            end
        end
    end

    assign UNDERVOLTAGE_THRESHOLD_CODE_OUT = uvt_q[1:0];
    assign STROBE_OUT           = strobe_q;
    assign BUCK_ONE_EN_OUT      = en_q[0] && POWER_ENABLE_INPUT_IN;
    assign BUCK_TWO_EN_OUT      = en_q[1] && POWER_ENABLE_INPUT_IN;
    assign BUCK_THREE_EN_OUT    = en_q[2] && POWER_ENABLE_INPUT_IN;
    assign LINREG_ONE_EN_OUT    = en_q[3];
    assign SYSTEM_SUPPLY_EN_OUT = sys_q;
    assign SEQ_DONE_OUT         = (state_q == SEQ_DONE);

    // Register file: masking, protection, write and read paths
    a_rsvd_reads_zero: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (uvt_q[7:3] == 5'h00) && !slot1_q[7] && !slot1_q[3] && !slot2_q[7])
        else $error("reserved bits not zero");

    a_locked_no_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (REG_WR_IN && !WR_UNLOCKED_IN) |=> $stable(uvt_q) && $stable(slot1_q)
        && $stable(slot2_q))
        else $error("write taken while locked");

    a_idle_regs_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        !(wr_uvt || wr_s1 || wr_s2) |=> $stable(uvt_q) && $stable(slot1_q)
        && $stable(slot2_q))
        else $error("register changed without a write");

    a_uvt_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        wr_uvt |=> uvt_q == ($past(REG_WDATA_IN) & UVT_WR_MASK))
        else $error("threshold write wrong");

    a_slot1_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        wr_s1 |=> slot1_q == ($past(REG_WDATA_IN) & SLOT_FIRST_MASK))
        else $error("first slot write wrong");

    a_slot2_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        wr_s2 |=> slot2_q == ($past(REG_WDATA_IN) & SLOT_SECOND_MASK))
        else $error("second slot write wrong");

    a_uvt_readback: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (REG_ADDR_IN == UVT_OFFSET) |=> REG_RDATA_OUT == $past(uvt_q))
        else $error("threshold read data wrong");

    // Power enable gating and abort
    a_buck_needs_pwr: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        !POWER_ENABLE_INPUT_IN |-> !BUCK_ONE_EN_OUT && !BUCK_TWO_EN_OUT && !BUCK_THREE_EN_OUT)
        else $error("buck on without power enable");

    a_pwr_low_clears: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        !POWER_ENABLE_INPUT_IN |=> (state_q == SEQ_IDLE) && (strobe_q == 4'h0)
        && (en_q == 4'h0) && !sys_q)
        else $error("power enable low did not clear the sequence");

    // Strobe stepping and delays
    a_strobe_ascends: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (POWER_ENABLE_INPUT_IN && $past(POWER_ENABLE_INPUT_IN) && $changed(strobe_q))
        |-> strobe_q == $past(strobe_q) + 4'h1)
        else $error("strobe not ascending");

    a_wait_holds_strobe: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (state_q == SEQ_WAIT && !tmr_done && POWER_ENABLE_INPUT_IN) |=> $stable(strobe_q))
        else $error("strobe moved before the delay ran out");

    a_done_at_last: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (state_q == SEQ_STEP && POWER_ENABLE_INPUT_IN && strobe_q == LAST_STROBE)
        |=> SEQ_DONE_OUT)
        else $error("sequence not done after the last strobe");

    // Rail enables follow the slot fields
    a_en_only_step: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (state_q != SEQ_STEP && POWER_ENABLE_INPUT_IN) |=> $stable(en_q))
        else $error("rail enable changed outside a strobe");

    a_buck_one_hit: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (state_q == SEQ_STEP && POWER_ENABLE_INPUT_IN && buck_one_slot != 3'h0
        && {1'b0, buck_one_slot} == strobe_q) |=> en_q[0])
        else $error("buck one not enabled at its strobe");

    a_zero_slot_idle: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (buck_one_slot == 3'h0 && $stable(buck_one_slot) && !$past(en_q[0])) |-> !en_q[0])
        else $error("unsequenced rail enabled");

    a_linreg_rsvd_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (linreg_one_slot[3:1] == 3'b100) |-> !hit[3])
        else $error("linreg codes 8 or 9 hit");

    a_linreg_high: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (state_q == SEQ_STEP && POWER_ENABLE_INPUT_IN && linreg_one_slot == LINREG_HIGH_MIN
        && strobe_q == LINREG_HIGH_MIN) |=> en_q[3])
        else $error("linreg not enabled at strobe 14");

    // System supply rides only with the last linreg strobe
    a_sys_with_last: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        $rose(sys_q) |-> $past(strobe_q) == 4'hf && en_q[3])
        else $error("system supply not at strobe 15");

    a_sys_only_last: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (state_q == SEQ_STEP && POWER_ENABLE_INPUT_IN && linreg_one_slot != LAST_STROBE)
        |=> $stable(sys_q))
        else $error("system supply moved without code 15");
endmodule

// File: test_rss_top.sv
// Self-checking testbench for the rail strobe sequencer configuration block
`timescale 1ns/10ps
module test_rss_top;
    import rss_pkg::*;
    localparam int MS = 10;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr = 1'b0, unl = 1'b0, pwr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, sdc = 8'h00, rdata;
    logic [1:0] code;
    logic [3:0] strobe;
    logic       b1, b2, b3, lin, system_supply, done;
    int         num_errors = 0;
    int         n_compared = 0;
    logic [7:0] tbl [8] = '{8'h77, 8'h7f, 8'h00, 8'h08, 8'h23, 8'h49, 8'h70, 8'h0e};

    rss_top #(.MS_CYCLES(MS)) DUT (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_WR_IN(wr),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .WR_UNLOCKED_IN(unl),
        .POWER_ENABLE_INPUT_IN(pwr), .SLOT_DELAY_CTRL_IN(sdc), .REG_RDATA_OUT(rdata),
        .UNDERVOLTAGE_THRESHOLD_CODE_OUT(code), .STROBE_OUT(strobe), .BUCK_ONE_EN_OUT(b1),
        .BUCK_TWO_EN_OUT(b2), .BUCK_THREE_EN_OUT(b3), .LINREG_ONE_EN_OUT(lin),
        .SYSTEM_SUPPLY_EN_OUT(system_supply), .SEQ_DONE_OUT(done));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic u);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        unl <= u;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1;
        chk("read data", exp, rdata);
    endtask

    function automatic bit lin_on(input logic [3:0] c);
        return (c >= 4'h1 && c <= 4'h7) || c >= LINREG_HIGH_MIN;
    endfunction

    function automatic int dly_cyc(input logic [7:0] d, input int k);
        logic [1:0] f;
        int         ms [4] = '{DLY0_MS, DLY1_MS, DLY2_MS, DLY3_MS};
        f = d[7 - 2 * (k % 4) -: 2];
        return ms[f] * MS;
    endfunction

    task automatic run_seq(input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] d,
                           input bit abort);
        int         n;
        bit         gap;
        bit         ahead;
        logic [3:0] prev;
        logic [2:0] f1, f2, f3;
        logic [3:0] fl;
        f1 = s1[6:4];
        f2 = s1[2:0];
        f3 = s2[6:4];
        fl = s2[3:0];
        n = 0;
        prev = 4'h0;
        wr_reg(SLOT_FIRST_OFFSET, s1, 1'b1);
        wr_reg(SLOT_SECOND_OFFSET, s2, 1'b1);
        sdc <= d;
        @(posedge clk);
        pwr <= 1'b1;
        repeat (2500)
        begin
            @(posedge clk);
            #1;
            n++;
            if (strobe !== prev)
            begin
                chk("strobe order", prev + 4'h1, strobe);
                if (prev != 0)
                begin
                    gap = n >= dly_cyc(d, prev) && n <= dly_cyc(d, prev) + 3;
                    chk("strobe spacing", 1, gap);
                end
                prev = strobe;
                n = 0;
            end
            ahead = (b1 && (f1 == 0 || strobe < f1)) || (b2 && (f2 == 0 || strobe < f2))
                    || (b3 && (f3 == 0 || strobe < f3));
            chk("rail ahead of strobe", 0, ahead);
            chk("linreg ahead of strobe", 0, lin && (!lin_on(fl) || strobe < fl));
            if ((abort && strobe == 4'h4) || done === 1'b1)
                break;
        end
        repeat (2) @(posedge clk);
        #1;
        if (!abort)
        begin
            chk("strobe final", LAST_STROBE, strobe);
            chk("buck enables", {f1 != 0, f2 != 0, f3 != 0}, {b1, b2, b3});
            chk("linreg enable", lin_on(fl), lin);
            chk("system supply", fl == LAST_STROBE, system_supply);
            chk("sequence done", 1, done);
        end
        @(posedge clk);
        pwr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("enables after power off", 0, {b1, b2, b3, lin, system_supply, done});
        $display("test sequence %h %h done", s1, s2);
    endtask

    initial
    begin
        logic [7:0] r;
        void'($urandom(83));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk("code after reset", 2'b11, code);
        rd_reg(UVT_OFFSET, UVT_RESET);
        rd_reg(SLOT_FIRST_OFFSET, SLOT_FIRST_RESET);
        rd_reg(SLOT_SECOND_OFFSET, SLOT_SECOND_RESET);
        wr_reg(UVT_OFFSET, 8'h00, 1'b0);
        rd_reg(UVT_OFFSET, UVT_RESET);
        wr_reg(UVT_OFFSET, 8'hff, 1'b1);
        rd_reg(UVT_OFFSET, 8'h07);
        wr_reg(8'h1b, 8'hff, 1'b1);
        rd_reg(8'h1b, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            r = 8'($urandom);
            wr_reg(UVT_OFFSET, r, 1'b1);
            rd_reg(UVT_OFFSET, r & UVT_WR_MASK);
            chk("threshold code", r[1:0], code);
            wr_reg(SLOT_FIRST_OFFSET, r, 1'b1);
            rd_reg(SLOT_FIRST_OFFSET, r & SLOT_FIRST_MASK);
            wr_reg(SLOT_SECOND_OFFSET, ~r, 1'b1);
            rd_reg(SLOT_SECOND_OFFSET, ~r & SLOT_SECOND_MASK);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++)
            run_seq(tbl[2 * i], tbl[2 * i + 1], 8'($urandom), 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            r = 8'($urandom % 16);
            if (r >= LINREG_FIRST_RSVD && r <= LINREG_LAST_RSVD)
                r = 8'h0f;
            run_seq(8'($urandom) & SLOT_FIRST_MASK, {1'b0, 3'($urandom), r[3:0]},
                    8'($urandom), i == 2);
        end
        report_and_stop();
    end

    initial
    begin
        // About 25k cycles, over twice the most that all tests can need (under 10k)
        #250_000;
        num_errors++;
        report_and_stop();
    end
endmodule
